//--- hdl/scl_link.sv
// Serial command link: line framing, command receive and response queue
`timescale 1ns/1ps
`include "scl_regs.svh"
`default_nettype none
module scl_link #(
  parameter int QDEPTH = 64,
  parameter int QAW = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings
  input wire logic [1:0] baud_sel,
  input wire logic [1:0] if_sel,
  input wire logic usb_keyboard,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Received command characters
  output logic [7:0] cmd_data,
  output logic cmd_valid,
  output logic cmd_end,
  // Response characters, queued; message end adds CR LF
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic rsp_value,
  // Status
  output logic query_error
);
  localparam logic [11:0] DIV0 = 12'(`SCL_CLK_HZ / (`SCL_BAUD_9600 * `SCL_OVS) - 1);
  localparam logic [11:0] DIV1 = 12'(`SCL_CLK_HZ / (`SCL_BAUD_19200 * `SCL_OVS) - 1);
  localparam logic [11:0] DIV2 = 12'(`SCL_CLK_HZ / (`SCL_BAUD_38400 * `SCL_OVS) - 1);
  localparam logic [11:0] DIV3 = 12'(`SCL_CLK_HZ / (`SCL_BAUD_115200 * `SCL_OVS) - 1);

  // Oversample tick; rate from settings, select code 0 gives 9600
  logic [11:0] div_cnt, next_div_cnt, div_top;
  logic tick, next_tick;
  always_comb begin
    case (baud_sel)
      `SCL_RATE_19200: div_top = DIV1; // [R1]
      `SCL_RATE_38400: div_top = DIV2; // [R1]
      `SCL_RATE_115200: div_top = DIV3; // [R1]
      default: div_top = DIV0; // [R1]
    endcase
    next_tick = 1'b0;
    next_div_cnt = div_cnt - 12'h001;
    if (div_cnt == 12'h000) begin
      next_div_cnt = div_top; // [R1]
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 12'h000;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick <= next_tick;
    end
  end

  // Receiver: commands only when RS-232 selected, never from USB
  logic cmd_ok;
  assign cmd_ok = (if_sel == `SCL_SEL_RS232); // [R4] [R6]
  scl_pkg::scl_rx_type rst_q, next_rst_q;
  logic [3:0] r_ovs, next_r_ovs, r_bit, next_r_bit;
  logic [7:0] r_sh, next_r_sh, next_cmd_data;
  logic next_cmd_valid, next_cmd_end, r_cr, next_r_cr;
  always_comb begin
    next_rst_q = rst_q;
    next_r_ovs = r_ovs;
    next_r_bit = r_bit;
    next_r_sh = r_sh;
    next_r_cr = r_cr;
    next_cmd_data = cmd_data;
    next_cmd_valid = 1'b0;
    next_cmd_end = 1'b0;
    if (tick) begin
      next_r_ovs = r_ovs + 4'h1;
      case (rst_q)
        scl_pkg::SCL_R_IDLE: begin
          next_r_ovs = 4'h0;
          if (!rxd) next_rst_q = scl_pkg::SCL_R_START;
        end
        scl_pkg::SCL_R_START: begin
          if (r_ovs == `SCL_OVS_MID) begin
            next_r_ovs = 4'h0;
            next_r_bit = 4'h0;
            next_rst_q = rxd ? scl_pkg::SCL_R_IDLE : scl_pkg::SCL_R_DATA;
          end
        end
        scl_pkg::SCL_R_DATA: begin
          if (r_ovs == `SCL_OVS_LAST) begin
            next_r_sh = {rxd, r_sh[7:1]}; // [R2]
            next_r_bit = r_bit + 4'h1;
            if (r_bit == `SCL_DATA_BITS - 4'h1) next_rst_q = scl_pkg::SCL_R_STOP;
          end
        end
        scl_pkg::SCL_R_STOP: begin
          if (r_ovs == `SCL_OVS_LAST) begin
            next_rst_q = scl_pkg::SCL_R_IDLE;
            // Bad stop bit or non-ASCII byte is dropped as line noise
            if (rxd && cmd_ok && r_sh <= `SCL_CHR_MAX) begin // [R2] [R3] [R4]
              if (r_sh == `SCL_CHR_CR) begin
                next_cmd_end = 1'b1; // [R7]
                next_r_cr = 1'b1;
              end else if (r_sh == `SCL_CHR_LF && r_cr) begin
                next_r_cr = 1'b0; // [R7]
              end else begin
                next_r_cr = 1'b0;
                next_cmd_data = r_sh;
                next_cmd_valid = 1'b1;
              end
            end
          end
        end
        default: next_rst_q = scl_pkg::SCL_R_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= scl_pkg::SCL_R_IDLE;
      r_ovs <= 4'h0;
      r_bit <= 4'h0;
      r_sh <= 8'h00;
      r_cr <= 1'b0;
      cmd_data <= 8'h00;
      cmd_valid <= 1'b0;
      cmd_end <= 1'b0;
    end else begin
      rst_q <= next_rst_q;
      r_ovs <= next_r_ovs;
      r_bit <= next_r_bit;
      r_sh <= next_r_sh;
      r_cr <= next_r_cr;
      cmd_data <= next_cmd_data;
      cmd_valid <= next_cmd_valid;
      cmd_end <= next_cmd_end;
    end
  end

  // Output queue: one entry per character, bit 8 marks message end
  logic [8:0] q_mem [QDEPTH];
  logic [QAW:0] q_wr, next_q_wr, q_rd, next_q_rd;
  logic next_query_error, q_pop, q_full, q_empty;
  logic [3:0] v_cnt, next_v_cnt;
  logic [7:0] v_chr;
  logic v_end;
  assign q_full = (q_wr[QAW] != q_rd[QAW]) && (q_wr[QAW-1:0] == q_rd[QAW-1:0]);
  assign q_empty = (q_wr == q_rd);
  always_comb begin
    next_q_wr = q_wr;
    next_q_rd = q_rd;
    next_v_cnt = v_cnt;
    // Clear first, so a push into a full queue in the same cycle still flags
    next_query_error = cmd_end ? 1'b0 : query_error; // [R9]
    v_chr = (rsp_data > `SCL_CHR_MAX) ? `SCL_CHR_SUBST : rsp_data; // [R3]
    v_end = rsp_last;
    if (q_pop) next_q_rd = q_rd + 1'b1;
    if (rsp_valid) begin
      if (rsp_value) begin
        // Value fields are not padded or cut; an end mark counts only on the eleventh character
        next_v_cnt = v_cnt + 4'h1; // [R5]
        v_end = 1'b0;
        if (v_cnt == `SCL_VALUE_LEN - 4'h1) begin
          next_v_cnt = 4'h0;
          v_end = rsp_last;
        end
      end
      if (q_full) begin
        // Overflow loses the whole queue; a character popped in this cycle is still sent
        next_query_error = 1'b1; // [R9]
        next_q_rd = q_wr; // [R9]
        next_v_cnt = 4'h0;
      end else begin
        next_q_wr = q_wr + 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rsp_valid && !q_full) q_mem[q_wr[QAW-1:0]] <= {v_end, v_chr};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_wr <= '0;
      q_rd <= '0;
      v_cnt <= 4'h0;
      query_error <= 1'b0;
    end else begin
      q_wr <= next_q_wr;
      q_rd <= next_q_rd;
      v_cnt <= next_v_cnt;
      query_error <= next_query_error;
    end
  end

  // Transmitter: after a character marked as end, CR and LF follow
  scl_pkg::scl_tx_type tst, next_tst;
  scl_pkg::scl_src_type src, next_src;
  logic [3:0] t_ovs, next_t_ovs, t_bit, next_t_bit;
  logic [7:0] t_sh, next_t_sh;
  logic next_txd;
  always_comb begin
    next_tst = tst;
    next_src = src;
    next_t_ovs = t_ovs;
    next_t_bit = t_bit;
    next_t_sh = t_sh;
    next_txd = txd;
    q_pop = 1'b0;
    case (tst)
      scl_pkg::SCL_T_IDLE: begin
        next_txd = 1'b1;
        if (src == scl_pkg::SCL_S_CR) begin
          next_t_sh = `SCL_CHR_CR; // [R7]
          next_src = scl_pkg::SCL_S_LF;
          next_tst = scl_pkg::SCL_T_START;
        end else if (src == scl_pkg::SCL_S_LF) begin
          next_t_sh = `SCL_CHR_LF; // [R7]
          next_src = scl_pkg::SCL_S_MSG;
          next_tst = scl_pkg::SCL_T_START;
        end else if (!q_empty) begin
          q_pop = 1'b1;
          next_t_sh = q_mem[q_rd[QAW-1:0]][7:0];
          next_src = q_mem[q_rd[QAW-1:0]][8] ? scl_pkg::SCL_S_CR : scl_pkg::SCL_S_MSG;
          next_tst = scl_pkg::SCL_T_START;
        end
        next_t_ovs = 4'h0;
      end
      scl_pkg::SCL_T_START: begin
        if (tick) begin
          next_txd = 1'b0; // [R2]
          next_t_ovs = t_ovs + 4'h1;
          if (t_ovs == `SCL_OVS_LAST) begin
            next_tst = scl_pkg::SCL_T_DATA;
            next_t_bit = 4'h0;
            next_txd = t_sh[0];
          end
        end
      end
      scl_pkg::SCL_T_DATA: begin
        if (tick) begin
          next_t_ovs = t_ovs + 4'h1;
          if (t_ovs == `SCL_OVS_LAST) begin
            next_t_sh = {1'b1, t_sh[7:1]}; // [R2]
            next_t_bit = t_bit + 4'h1;
            next_txd = t_sh[1];
            if (t_bit == `SCL_DATA_BITS - 4'h1) begin
              next_tst = scl_pkg::SCL_T_STOP;
              next_txd = 1'b1;
            end
          end
        end
      end
      scl_pkg::SCL_T_STOP: begin
        if (tick) begin
          next_t_ovs = t_ovs + 4'h1;
          if (t_ovs == `SCL_OVS_LAST) next_tst = scl_pkg::SCL_T_IDLE; // [R2]
        end
      end
      default: next_tst = scl_pkg::SCL_T_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tst <= scl_pkg::SCL_T_IDLE;
      src <= scl_pkg::SCL_S_MSG;
      t_ovs <= 4'h0;
      t_bit <= 4'h0;
      t_sh <= 8'h00;
      txd <= 1'b1;
    end else begin
      tst <= next_tst;
      src <= next_src;
      t_ovs <= next_t_ovs;
      t_bit <= next_t_bit;
      t_sh <= next_t_sh;
      txd <= next_txd;
    end
  end
endmodule
`default_nettype wire

//--- hdl/scl_pkg.sv
// Types of the serial command link
`default_nettype none
package scl_pkg;
  typedef enum logic [1:0] {SCL_R_IDLE, SCL_R_START, SCL_R_DATA, SCL_R_STOP} scl_rx_type;
  typedef enum logic [1:0] {SCL_T_IDLE, SCL_T_START, SCL_T_DATA, SCL_T_STOP} scl_tx_type;
  typedef enum logic [1:0] {SCL_S_MSG, SCL_S_CR, SCL_S_LF, SCL_S_VAL} scl_src_type;
endpackage
`default_nettype wire

//--- hdl/scl_regs.svh
// Constants of the serial command link
// Contract
// [R1] Four bit rates 9600/19200/38400/115200, reset selects 9600; here reset does not touch the rate, which always follows baud_sel.
// [R2] Frame is start, eight data, no parity, one stop: ten bit periods.
// [R3] Characters on the link are ASCII codes.
// [R4] Commands accepted only from the interface selected in settings.
// [R5] Every transmitted measured value is exactly eleven characters; the code counts them but neither pads nor cuts.
// [R6] USB keyboard mode only outputs data, never accepts commands.
// [R7] Receive ends on CR or CR LF; transmit always ends CR LF.
// [R8] Controller uses 8N1, no flow control, at the selected rate.
// [R9] Output queue overflow flags query error and clears the queue.
`ifndef SCL_REGS_SVH
`define SCL_REGS_SVH
`define SCL_CLK_HZ 25000000
`define SCL_BAUD_9600 9600
`define SCL_BAUD_19200 19200
`define SCL_BAUD_38400 38400
`define SCL_BAUD_115200 115200
`define SCL_OVS 16
`define SCL_DATA_BITS 4'h8
`define SCL_OVS_MID 4'h7
`define SCL_OVS_LAST 4'hf
`define SCL_CHR_CR 8'h0d
`define SCL_CHR_LF 8'h0a
`define SCL_CHR_MAX 8'h7f
`define SCL_VALUE_LEN 4'hb
`define SCL_SEL_RS232 2'h0
`define SCL_SEL_USB 2'h1
`define SCL_RATE_19200 2'h1
`define SCL_RATE_38400 2'h2
`define SCL_RATE_115200 2'h3
`define SCL_CHR_SUBST 8'h3f
`endif

//--- tb/scl_host.sv
// Host controller model on the serial line
`timescale 1ns/1ps
`default_nettype none
module scl_host #(
  parameter int BIT_CLKS = 208
) (
  // Clock
  input wire logic clk,
  // Serial line
  output logic line_out,
  input wire logic line_in
);
  // Mark level between frames, as an idle line rests
  initial line_out = 1'b1;
  // Bit length of sent frames; the bench may change it for another rate
  int bit_clks = BIT_CLKS;
  // Start, eight data LSB first, stop; no flow control
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      line_out = f[i];
      repeat (bit_clks - 1) @(negedge clk);
    end
  endtask
  // Samples mid bit; returns stop bit above data, unknown on timeout
  task automatic recv(output logic [8:0] f);
    int n;
    n = 0;
    f = 'x;
    while (line_in !== 1'b0 && n < 20000) begin
      @(negedge clk);
      n++;
    end
    if (n < 20000) begin
      repeat (BIT_CLKS / 2) @(negedge clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CLKS) @(negedge clk);
        f[i] = line_in;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/scl_link_chk.sv
// Assertions on the serial command link ports
`timescale 1ns/1ps
`default_nettype none
module scl_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [1:0] if_sel,
  input wire logic usb_keyboard,
  input wire logic txd,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_end,
  input wire logic rsp_valid,
  input wire logic query_error
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  rx_ascii_a: assert property (cmd_valid |-> !cmd_data[7])
    else $error("non ascii command char");
  cr_apart_a: assert property (cmd_valid |-> cmd_data != 8'h0d && !cmd_end)
    else $error("carriage return passed as data");
  sel_only_a: assert property ((if_sel != 2'h0)[*8] |-> !cmd_valid && !cmd_end)
    else $error("command taken from inactive interface");
  kbd_mode_a: assert property (usb_keyboard && if_sel == 2'h1 |-> !cmd_valid)
    else $error("command taken in keyboard mode");
  cmd_gap_a: assert property (cmd_valid |=> !cmd_valid[*8])
    else $error("characters closer than a frame");
  start_bit_a: assert property ($fell(txd) |-> !txd[*8])
    else $error("start bit too short");
  qerr_set_a: assert property ($rose(query_error) |-> $past(rsp_valid))
    else $error("query error without push");
  qerr_hold_a: assert property (query_error && !cmd_end |=> query_error)
    else $error("query error dropped early");
  // A push in the same cycle may set the flag again, since the set wins
  qerr_clr_a: assert property (cmd_end && !rsp_valid |=> !query_error)
    else $error("query error not cleared");
  cover property (cmd_end);
  cover property ($rose(query_error));
  cover property ($fell(txd));
endmodule
bind scl_link scl_link_chk u_scl_link_chk (.clk, .rst_n, .if_sel, .usb_keyboard, .txd,
  .cmd_data, .cmd_valid, .cmd_end, .rsp_valid, .query_error);
`default_nettype wire

//--- tb/serial_command_link_tb_top.sv
// Testbench top of the serial command link
`timescale 1ns/1ps
`default_nettype none
module serial_command_link_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] baud_sel = 2'h3;
  logic [1:0] if_sel = 2'h0;
  logic usb_keyboard = 1'b0;
  logic rxd;
  logic txd;
  logic [7:0] cmd_data;
  logic cmd_valid;
  logic cmd_end;
  logic [7:0] rsp_data = 8'h00;
  logic rsp_valid = 1'b0;
  logic rsp_last = 1'b0;
  logic rsp_value = 1'b0;
  logic query_error;
  int n_errors = 0;
  int checks_done = 0;
  int n_end = 0;
  logic [7:0] got[$];
  always #20 clk = ~clk;
  scl_link u_scl_link (.clk(clk), .rst_n(rst_n), .baud_sel(baud_sel), .if_sel(if_sel),
    .usb_keyboard(usb_keyboard), .rxd(rxd), .txd(txd), .cmd_data(cmd_data),
    .cmd_valid(cmd_valid), .cmd_end(cmd_end), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_value(rsp_value), .query_error(query_error));
  // 115200 at 13 clocks a tick, 16 ticks a bit
  scl_host #(.BIT_CLKS(208)) u_scl_host (.clk(clk), .line_out(rxd), .line_in(txd));
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) got.push_back(cmd_data);
    if (cmd_end === 1'b1) n_end++;
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rx_frames(input logic [1:0] sel, input logic kbd, input int n_exp);
    got.delete();
    n_end = 0;
    if_sel = sel;
    usb_keyboard = kbd;
    u_scl_host.send(8'h41);
    u_scl_host.send(8'h0d);
    u_scl_host.send(8'h0a);
    repeat (400) @(negedge clk);
    check("cmd count", 9'(got.size()), 9'(n_exp));
    if (n_exp > 0) check("cmd char", {1'b0, got[0]}, 9'h041);
    check("cmd end", 9'(n_end), 9'(n_exp));
    if_sel = 2'h0;
    usb_keyboard = 1'b0;
  endtask
  task automatic tx_value();
    string s;
    logic [8:0] f;
    s = "+1.2345E+00";
    fork
      begin
        for (int i = 0; i < 11; i++) begin
          @(negedge clk);
          rsp_data = s[i];
          rsp_valid = 1'b1;
          rsp_value = 1'b1;
          // An early end mark inside a value field must be ignored
          rsp_last = (i == 3 || i == 10);
        end
        @(negedge clk);
        rsp_valid = 1'b0;
      end
      for (int i = 0; i < 13; i++) begin
        u_scl_host.recv(f);
        check("tx frame", f, {1'b1, i < 11 ? s[i] : (i == 11 ? 8'h0d : 8'h0a)});
      end
    join
  endtask
  task automatic overflow();
    int k;
    // Let the last reply drain, so the first push is popped at once;
    // 64 more fill the queue and the 66th overflows as the last push
    repeat (400) @(negedge clk);
    for (int i = 0; i < 66; i++) begin
      @(negedge clk);
      rsp_data = 8'h30;
      rsp_valid = 1'b1;
      rsp_value = 1'b0;
      rsp_last = 1'b0;
    end
    @(negedge clk);
    rsp_valid = 1'b0;
    check("query error set", {8'h00, query_error}, 9'h001);
    u_scl_host.send(8'h0d);
    repeat (400) @(negedge clk);
    check("query error clear", {8'h00, query_error}, 9'h000);
    // A kept queue would still be sending here
    k = 0;
    repeat (2500) @(negedge clk) k += int'(txd !== 1'b1);
    check("queue dropped", 9'(k), 9'h000);
  endtask
  task automatic rx_rate();
    got.delete();
    baud_sel = 2'h2;
    // Host runs at the true 38400 rate, not the divided one
    u_scl_host.bit_clks = 651;
    repeat (50) @(negedge clk);
    u_scl_host.send(8'h52);
    repeat (400) @(negedge clk);
    check("rate count", 9'(got.size()), 9'h001);
    if (got.size() > 0) check("rate char", {1'b0, got[0]}, 9'h052);
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("txd idle", {8'h00, txd}, 9'h001);
    rx_frames(2'h0, 1'b0, 1);
    rx_frames(2'h1, 1'b1, 0);
    tx_value();
    overflow();
    rx_rate();
    give_verdict();
  end
endmodule
`default_nettype wire
